// ### verilog/epc_top.sv
// page cache and array write-back of a two-wire serial nonvolatile memory
// assumes an array port that takes one masked page write per strobe,
// a supply monitor that can be switched off, and an external pull-up on sda
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1: aligned start writes every cached byte to consecutive addresses, crossing blocks
// RULE2: one self-timed programming cycle for each cache page, one after another
// RULE3: first byte lands in cache page 0 at slot from low address bits
// RULE4: unaligned full load rolls final bytes into empty slots of page 0
// RULE5: beyond 64 bytes the slot index wraps and overwrites older bytes
// RULE6: on stop, cache page 0 goes to start page, then successive pages
// RULE7: partly filled page programs only the bytes actually received
// RULE8: return to standby after stop once programming is finished
// RULE9: aborted transaction also falls back to standby
// RULE10: no array programming while supply monitor reports low voltage
// RULE11: supply monitor off in standby, on while active
// RULE12: respond only when control byte select bits match the strap pins
// RULE13: data pin is open drain, pulled low or released only
// RULE14: data changes only while clock low; changes while high are start/stop
// RULE15: serial clock is only an input timing every bit
// RULE16: cache is eight pages of eight bytes, loaded from command to stop
// RULE17: each page cycle lasts at most 5 ms, partial pages alike
// RULE18: while programming, ignore commands and withhold acknowledge
// RULE19: per-byte valid flags cleared at command, set on store, steer programming
module epc_top #(
    parameter int PAGE_CYCLES = epc_pkg::EPC_PAGE_CYCLES
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // serial bus pins, clock is the link clock
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // chip address straps
    input wire logic chip_addr_pin_0_i,
    input wire logic chip_addr_pin_1_i,
    input wire logic chip_addr_pin_2_i,
    // supply monitor
    input wire logic low_volt_i,
    output logic vmon_en_o,
    // array write port
    output epc_pkg::epc_arr_wr_t arr_wr_o,
    output logic busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // state of the core domain
    typedef struct packed {
        epc_pkg::epc_state_t st;
        logic scl_l;
        logic sda_l;
        logic tog_seen;
        logic [epc_pkg::EPC_AHI_W-1:0] addr_hi;
        logic [epc_pkg::EPC_PAGE_W-1:0] base_page;
        logic [epc_pkg::EPC_SLOT_W-1:0] slot;
        logic [2:0] page;
        logic [epc_pkg::EPC_TMR_W-1:0] tmr;
        logic [epc_pkg::EPC_CACHE_BYTES-1:0] valid;
        logic [epc_pkg::EPC_CACHE_BYTES-1:0][7:0] cache;
        logic vmon_en;
        logic busy;
        logic sda_lvl;
        epc_pkg::epc_arr_wr_t wr;
    } epc_core_t;

    epc_core_t c_q;
    epc_core_t c_d;

    // filtered pins and link events
    logic [3:0] pins_f;
    logic scl_f;
    logic sda_f;
    logic lowv_f;
    logic tog_f;
    logic start_ev;
    logic stop_ev;
    logic byte_ev;
    logic low_ok;
    epc_pkg::epc_rx_t rx;
    logic rx_tog;
    logic link_oe;

    // last timer count of one page cycle
    localparam logic [epc_pkg::EPC_TMR_W-1:0] TMR_LAST =
        epc_pkg::EPC_TMR_W'(PAGE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // page p of the cache has at least one stored byte
    function automatic logic page_used(
        input logic [epc_pkg::EPC_CACHE_BYTES-1:0] v,
        input logic [2:0] p
    );
        page_used = |v[p * epc_pkg::EPC_PAGE_BYTES +: epc_pkg::EPC_PAGE_BYTES];
    endfunction

    // any page from p upward still holds stored bytes
    function automatic logic more_used(
        input logic [epc_pkg::EPC_CACHE_BYTES-1:0] v,
        input logic [2:0] p
    );
        logic r;
        r = 1'b0;
        for (int i = 0; i < epc_pkg::EPC_PAGES; i++) begin
            if (i >= int'(p)) begin
                r = r | page_used(v, 3'(i));
            end
        end
        more_used = r;
    endfunction

    // eight bytes of cache page p, byte 0 in the low lane
    function automatic logic [63:0] page_data(
        input logic [epc_pkg::EPC_CACHE_BYTES-1:0][7:0] c,
        input logic [2:0] p
    );
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < epc_pkg::EPC_PAGE_BYTES; i++) begin
            r[i * 8 +: 8] = c[p * epc_pkg::EPC_PAGE_BYTES + i];
        end
        page_data = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin and toggle synchronisers into the core clock
    epc_sync3 #(.W(4)) u_pin_sync (
        .clk_i(mclk_i),
        .rst_i(sys_rst_i),
        .d_i({scl_i, sda_i, low_volt_i, rx_tog}),
        .q_o(pins_f)
    );

    assign scl_f = pins_f[3];
    assign sda_f = pins_f[2];
    assign lowv_f = pins_f[1];
    assign tog_f = pins_f[0];

    ////////////////////////////////////////////////////////////////////////////
    // link front end on the serial clock
    epc_link u_link (
        .sys_rst_i(sys_rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_oe_o(link_oe),
        .chip_addr_i({chip_addr_pin_2_i, chip_addr_pin_1_i, chip_addr_pin_0_i}),
        .busy_i(c_q.busy),
        .rx_o(rx),
        .rx_tog_o(rx_tog)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus conditions seen from the core
    // RULE14: start and stop from data edges while clock high
    assign start_ev = scl_f && c_q.scl_l && c_q.sda_l && !sda_f;
    assign stop_ev = scl_f && c_q.scl_l && !c_q.sda_l && sda_f;
    // byte from the link; its data stands until the next toggle
    assign byte_ev = tog_f != c_q.tog_seen;
    // RULE10: low supply blocks programming
    assign low_ok = !(c_q.vmon_en && lowv_f);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic of the core
    always_comb begin
        c_d = c_q;
        c_d.scl_l = scl_f;
        c_d.sda_l = sda_f;
        c_d.tog_seen = tog_f;
        c_d.sda_lvl = 1'b0;
        c_d.wr.we = 1'b0;
        case (c_q.st)
            // RULE11: monitor off in standby
            epc_pkg::EPC_ST_STANDBY: begin
                c_d.vmon_en = 1'b0;
                if (start_ev) begin
                    c_d.st = epc_pkg::EPC_ST_ACTIVE;
                    c_d.vmon_en = 1'b1;
                end
            end
            epc_pkg::EPC_ST_ACTIVE: begin
                // RULE9: abort or foreign frame ends in standby
                if (stop_ev) begin
                    c_d.st = epc_pkg::EPC_ST_STANDBY;
                end else if (byte_ev && rx.idx == epc_pkg::EPC_IDX_CTRL) begin
                    // RULE19: flags cleared at command start
                    c_d.valid = '0;
                    c_d.st = epc_pkg::EPC_ST_LOAD;
                end
            end
            epc_pkg::EPC_ST_LOAD: begin
                if (start_ev) begin
                    // repeated start drops the load
                    c_d.st = epc_pkg::EPC_ST_ACTIVE;
                end else if (stop_ev) begin
                    // RULE6: stop launches write-back at cache page 0
                    c_d.page = epc_pkg::EPC_PAGE_ZERO;
                    c_d.tmr = '0;
                    if (|c_q.valid) begin
                        c_d.st = epc_pkg::EPC_ST_PROG;
                        c_d.busy = 1'b1;
                    end else begin
                        c_d.st = epc_pkg::EPC_ST_STANDBY;
                    end
                end else if (byte_ev) begin
                    if (rx.idx == epc_pkg::EPC_IDX_AHI) begin
                        c_d.addr_hi = rx.data[epc_pkg::EPC_AHI_W-1:0];
                    end else if (rx.idx == epc_pkg::EPC_IDX_ALO) begin
                        // RULE3: first slot from low address bits in page 0
                        c_d.base_page = {c_q.addr_hi, rx.data[7:epc_pkg::EPC_OFS_W]};
                        c_d.slot = {3'h0, rx.data[epc_pkg::EPC_OFS_W-1:0]};
                    end else if (rx.idx == epc_pkg::EPC_IDX_DATA) begin
                        // RULE16: store into the cache
                        c_d.cache[c_q.slot] = rx.data;
                        // RULE19: mark the byte stored
                        c_d.valid[c_q.slot] = 1'b1;
                        // RULE4: wrap back into page 0
                        // RULE5: overwrite past 64 bytes
                        c_d.slot = c_q.slot + epc_pkg::EPC_SLOT_ONE;
                    end
                end
            end
            epc_pkg::EPC_ST_PROG: begin
                c_d.tmr = '0;
                if (!more_used(c_q.valid, c_q.page) || !low_ok) begin
                    // RULE10: nothing programmed on low supply
                    // RULE8: nothing left, back to standby
                    c_d.st = epc_pkg::EPC_ST_STANDBY;
                    c_d.busy = 1'b0;
                    c_d.vmon_en = 1'b0;
                end else begin
                    // RULE1: consecutive array pages across blocks
                    // RULE6: cache page n to start page plus n
                    c_d.wr.we = 1'b1;
                    c_d.wr.page = c_q.base_page + epc_pkg::EPC_PAGE_W'(c_q.page);
                    c_d.wr.data = page_data(c_q.cache, c_q.page);
                    // RULE7: only received bytes enabled
                    c_d.wr.mask = c_q.valid[c_q.page * epc_pkg::EPC_PAGE_BYTES +: 8];
                    c_d.st = epc_pkg::EPC_ST_WAIT;
                end
            end
            epc_pkg::EPC_ST_WAIT: begin
                // RULE17: fixed cycle per page, full or partial
                // RULE2: one timed cycle per page
                if (c_q.tmr == TMR_LAST) begin
                    c_d.tmr = '0;
                    if (c_q.page == epc_pkg::EPC_LAST_PAGE) begin
                        // RULE8: all pages done
                        c_d.st = epc_pkg::EPC_ST_STANDBY;
                        c_d.busy = 1'b0;
                        c_d.vmon_en = 1'b0;
                    end else begin
                        c_d.page = c_q.page + 3'h1;
                        c_d.st = epc_pkg::EPC_ST_PROG;
                    end
                end else begin
                    c_d.tmr = c_q.tmr + epc_pkg::EPC_TMR_ONE;
                end
            end
            default: begin
                c_d.st = epc_pkg::EPC_ST_STANDBY;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // core state register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            c_q <= '0;
            c_q.scl_l <= 1'b1;
            c_q.sda_l <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    // RULE13: level is always low, enable pulls
    assign sda_o = c_q.sda_lvl;
    assign sda_oe_o = link_oe;
    assign vmon_en_o = c_q.vmon_en;
    assign arr_wr_o = c_q.wr;
    // RULE18: busy holds off acknowledge
    assign busy_o = c_q.busy;

endmodule

// ### verilog/epc_pkg.sv
// constants and carrier types of the page cache write-back block
// assumes a 125 MHz core clock and a 13-bit byte address space
package epc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // control byte and framing
    localparam logic [3:0] EPC_CTRL_CODE = 4'hA;  // device type code of the control byte
    localparam logic EPC_RW_WRITE = 1'h0;
    localparam logic [3:0] EPC_ACK_CNT = 4'h8;    // bits seen before the ack slot
    localparam logic [3:0] EPC_CNT_ZERO = 4'h0;
    localparam logic [3:0] EPC_CNT_ONE = 4'h1;
    localparam logic [1:0] EPC_IDX_CTRL = 2'h0;
    localparam logic [1:0] EPC_IDX_AHI = 2'h1;
    localparam logic [1:0] EPC_IDX_ALO = 2'h2;
    localparam logic [1:0] EPC_IDX_DATA = 2'h3;
    localparam logic [1:0] EPC_IDX_ONE = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // cache and array geometry
    localparam int EPC_PAGE_BYTES = 8;
    localparam int EPC_PAGES = 8;
    localparam int EPC_CACHE_BYTES = 64;
    localparam int EPC_PAGE_W = 10;      // array page number width
    localparam int EPC_AHI_W = 5;        // used bits of the high address byte
    localparam int EPC_OFS_W = 3;        // byte within a page
    localparam int EPC_SLOT_W = 6;       // byte within the cache
    localparam logic [2:0] EPC_LAST_PAGE = 3'h7;
    localparam logic [2:0] EPC_PAGE_ZERO = 3'h0;
    localparam logic [5:0] EPC_SLOT_ONE = 6'h01;

    ////////////////////////////////////////////////////////////////////////////
    // self-timed page write
    localparam int EPC_PAGE_TIME_MS = 5;
    localparam int EPC_CLK_MHZ = 125;
    localparam int EPC_PAGE_CYCLES = EPC_PAGE_TIME_MS * 1000 * EPC_CLK_MHZ;
    localparam int EPC_TMR_W = 20;
    localparam logic [19:0] EPC_TMR_ONE = 20'h00001;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        EPC_ST_STANDBY = 3'h0,
        EPC_ST_ACTIVE = 3'h1,
        EPC_ST_LOAD = 3'h3,
        EPC_ST_PROG = 3'h2,
        EPC_ST_WAIT = 3'h6
    } epc_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic [1:0] idx;
    } epc_rx_t;

    typedef struct packed {
        logic we;
        logic [9:0] page;
        logic [63:0] data;
        logic [7:0] mask;
    } epc_arr_wr_t;

endpackage

// ### verilog/epc_sync3.sv
// three-stage synchroniser with agreement filter
// assumes d_i is asynchronous to clk_i; q_o follows once stages two and three agree
`timescale 1ns/10ps
module epc_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } epc_sync_t;

    epc_sync_t r_q;
    epc_sync_t r_d;

    ////////////////////////////////////////////////////////////////////////////
    // shift chain, output updated per bit when stages agree
    always_comb begin
        r_d = r_q;
        r_d.s1 = d_i;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.q = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 | r_q.s3));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q_o = r_q.q;

endmodule

// ### verilog/epc_link.sv
// serial link front end on the bus clock: bit shift, framing and ack
// assumes scl_i idles high outside frames; reset clears its flip-flops without a clock edge, except u_sync, which clears only on a rising scl_i
`timescale 1ns/10ps
module epc_link (
    // reset
    input wire logic sys_rst_i,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    // straps and core state
    input wire logic [2:0] chip_addr_i,
    input wire logic busy_i,
    // received byte toward the core
    output epc_pkg::epc_rx_t rx_o,
    output logic rx_tog_o
);

    typedef struct packed {
        logic [3:0] cnt;
        logic [1:0] idx;
        logic sel;
        logic oe;
        logic tog;
        logic seen;
        epc_pkg::epc_rx_t rx;
    } epc_lnk_t;

    logic [7:0] sh_q;
    logic start_q;
    logic [3:0] slow;
    epc_lnk_t t_q;
    epc_lnk_t t_d;

    // busy and strap levels, filtered on the bus clock
    epc_sync3 #(.W(4)) u_sync (
        .clk_i(scl_i),
        .rst_i(sys_rst_i),
        .d_i({busy_i, chip_addr_i}),
        .q_o(slow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // RULE14: start marks, data falling while clock high
    always_ff @(negedge sda_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            start_q <= 1'b0;
        end else if (scl_i) begin
            start_q <= ~start_q;
        end
    end

    // RULE15: bits sampled on clock rise
    always_ff @(posedge scl_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sh_q <= '0;
        end else begin
            sh_q <= {sh_q[6:0], sda_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // framing and ack decision on the falling clock edge
    always_comb begin
        t_d = t_q;
        if (start_q != t_q.seen) begin
            t_d.seen = start_q;
            t_d.cnt = epc_pkg::EPC_CNT_ZERO;
            t_d.idx = epc_pkg::EPC_IDX_CTRL;
            t_d.sel = 1'b1;
            t_d.oe = 1'b0;
        end else if (!t_q.sel) begin
            t_d.oe = 1'b0;
        end else if (t_q.cnt == epc_pkg::EPC_ACK_CNT) begin
            t_d.cnt = epc_pkg::EPC_CNT_ZERO;
            t_d.oe = 1'b0;
            if (t_q.idx != epc_pkg::EPC_IDX_DATA) begin
                t_d.idx = t_q.idx + epc_pkg::EPC_IDX_ONE;
            end
        end else if (t_q.cnt == epc_pkg::EPC_ACK_CNT - epc_pkg::EPC_CNT_ONE) begin
            t_d.cnt = epc_pkg::EPC_ACK_CNT;
            // RULE12: respond only to our strap
            // RULE18: silent while programming
            // all eight bits already shifted in on the preceding clock rise
            if (t_q.idx != epc_pkg::EPC_IDX_CTRL
                || (sh_q[7:4] == epc_pkg::EPC_CTRL_CODE && sh_q[3:1] == slow[2:0]
                    && sh_q[0] == epc_pkg::EPC_RW_WRITE && !slow[3])) begin
                t_d.oe = 1'b1;
                t_d.tog = ~t_q.tog;
                t_d.rx.data = sh_q;
                t_d.rx.idx = t_q.idx;
            end else begin
                t_d.sel = 1'b0;
            end
        end else begin
            t_d.cnt = t_q.cnt + epc_pkg::EPC_CNT_ONE;
        end
    end

    // RULE13: pin only ever pulled low
    always_ff @(negedge scl_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign sda_oe_o = t_q.oe;
    assign rx_o = t_q.rx;
    assign rx_tog_o = t_q.tog;

endmodule

// ### tb/epc_checker.sv
// checker for the page cache write-back block
// assumes it is bound to epc_top with the same page time parameter
`timescale 1ns/10ps
module epc_checker #(
    parameter int PAGE_CYCLES = 20
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // straps and supply monitor
    input wire logic chip_addr_pin_0_i,
    input wire logic chip_addr_pin_1_i,
    input wire logic chip_addr_pin_2_i,
    input wire logic low_volt_i,
    input wire logic vmon_en_o,
    // array port
    input wire epc_pkg::epc_arr_wr_t arr_wr_o,
    input wire logic busy_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    int gap_q;
    logic seen_q;
    logic [9:0] page_q;
    ////////////////////////////////////////////////////////////////////////////
    // cycles since busy rose or since the last page write
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !busy_o) begin
            gap_q <= 0;
            seen_q <= 1'h0;
        end else if (arr_wr_o.we) begin
            gap_q <= 1;
            seen_q <= 1'h1;
        end else begin
            gap_q <= gap_q + 1;
        end
        if (arr_wr_o.we) begin
            page_q <= arr_wr_o.page;
        end
    end
    // pin and write-back relations
    chk_sda_low_only: assert property (!sda_o)
        else $error("data pin driven high");
    chk_we_busy: assert property (arr_wr_o.we |-> busy_o)
        else $error("page write outside write-back");
    chk_we_gap: assert property (arr_wr_o.we && seen_q |-> gap_q == PAGE_CYCLES + 1)
        else $error("page write spacing wrong");
    chk_page_step: assert property (arr_wr_o.we && seen_q |-> arr_wr_o.page == page_q + 10'h001)
        else $error("page number not successive");
    chk_busy_bound: assert property (busy_o |-> gap_q <= PAGE_CYCLES + 4)
        else $error("write-back does not finish");
    chk_vmon_busy: assert property (busy_o |-> vmon_en_o)
        else $error("monitor off during write-back");
    chk_vmon_off: assert property ($fell(busy_o) |-> ##[0:2] !vmon_en_o)
        else $error("monitor left on in standby");
    chk_lowv_block: assert property ((vmon_en_o && low_volt_i) [*6] |-> !arr_wr_o.we)
        else $error("page write under low supply");
    chk_ack_busy: assert property (busy_o [*8] |-> !sda_oe_o)
        else $error("acknowledge while busy");
    chk_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data pin moved while clock high");
    // main scenarios
    cov_partial: cover property (arr_wr_o.we && arr_wr_o.mask != 8'hFF);
    cov_done: cover property ($fell(busy_o));
    cov_ack: cover property (sda_oe_o);
endmodule

// ### tb/epc_master.sv
// two-wire bus master model for the write path
// assumes an external pull-up; clock stands high between frames
`timescale 1ns/10ps
module epc_master (
    // serial pins
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    // idle bus
    initial begin
        scl_o = 1'h1;
        sda_oe_o = 1'h0;
    end
    // start or repeated start, data falls while clock high
    task automatic start();
        sda_oe_o = 1'h0;
        #20;
        scl_o = 1'h1;
        #20;
        sda_oe_o = 1'h1;
        #40;
        scl_o = 1'h0;
        #20;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_oe_o = ~b[i];
            #20;
            scl_o = 1'h1;
            #40;
            scl_o = 1'h0;
            #20;
        end
        sda_oe_o = 1'h0;
        #20;
        scl_o = 1'h1;
        #20;
        ack = ~sda_i;
        #20;
        scl_o = 1'h0;
        #20;
    endtask
    // stop, data rises while clock high
    task automatic stop();
        sda_oe_o = 1'h1;
        #20;
        scl_o = 1'h1;
        #40;
        sda_oe_o = 1'h0;
        #40;
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for the page cache write-back block
// assumes a short page time parameter and the master model
`timescale 1ns/10ps
module testbench;
    localparam int PC = 20;
    logic mclk, sys_rst, scl, sda, sda_o, dut_oe, mst_oe, low_volt, vmon_en, busy;
    logic [2:0] strap;
    epc_pkg::epc_arr_wr_t arr_wr;
    epc_pkg::epc_arr_wr_t exp_q[$];
    logic [7:0] cache [64];
    logic [63:0] valid;
    int failures = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////
    // wire level of the open-drain data line with pull-up
    assign sda = (dut_oe ? sda_o : 1'h1) & ~mst_oe;
    epc_master i_mst (.scl_o(scl), .sda_oe_o(mst_oe), .sda_i(sda));
    epc_top #(.PAGE_CYCLES(PC)) i_dut (.mclk_i(mclk), .sys_rst_i(sys_rst), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(dut_oe), .chip_addr_pin_0_i(strap[0]),
        .chip_addr_pin_1_i(strap[1]), .chip_addr_pin_2_i(strap[2]), .low_volt_i(low_volt),
        .vmon_en_o(vmon_en), .arr_wr_o(arr_wr), .busy_o(busy));
    // core clock
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    // compare tasks and verdict
    task automatic cmp_bit(input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_wr(input epc_pkg::epc_arr_wr_t e, input epc_pkg::epc_arr_wr_t g);
        logic [63:0] m;
        for (int i = 0; i < 8; i++) m[8*i+:8] = {8{e.mask[i]}};
        tests_run++;
        if ({g.page, g.mask, g.data & m} !== {e.page, e.mask, e.data & m}) begin
            failures++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, {e.page, e.mask, e.data & m},
                {g.page, g.mask, g.data & m});
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one write frame; notes the page writes it should cause
    task automatic wframe(input logic [2:0] sel, input logic [12:0] a, input int n,
                          input logic fin, input logic wr_ok, output logic ack);
        epc_pkg::epc_arr_wr_t e;
        logic [7:0] b;
        logic a1;
        int last;
        @(posedge mclk);
        #1;
        valid = '0;
        i_mst.start();
        i_mst.send({epc_pkg::EPC_CTRL_CODE, sel, epc_pkg::EPC_RW_WRITE}, ack);
        if (ack === 1'h1) begin
            i_mst.send({3'h0, a[12:8]}, a1);
            i_mst.send(a[7:0], a1);
            for (int k = 0; k < n; k++) begin
                b = 8'($urandom);
                i_mst.send(b, a1);
                cache[(a[2:0] + k) % 64] = b;
                valid[(a[2:0] + k) % 64] = 1'h1;
            end
        end
        last = -1;
        for (int s = 0; s < 64; s++) if (valid[s]) last = s / 8;
        for (int p = 0; p <= last && fin && wr_ok; p++) begin
            e.we = 1'h1;
            e.page = 10'(a[12:3] + p);
            e.mask = valid[8*p+:8];
            for (int i = 0; i < 8; i++) e.data[8*i+:8] = cache[8*p+i];
            exp_q.push_back(e);
        end
        if (fin) i_mst.stop();
    endtask
    // bounded wait for standby, then idle checks
    task automatic wait_idle(input int t);
        int i;
        i = 0;
        repeat (12) @(posedge mclk);
        while (busy !== 1'h0 && i < 600) begin
            @(posedge mclk);
            i++;
        end
        repeat (2) @(posedge mclk);
        #1;
        cmp_bit(1'h1, i < 600);
        cmp_bit(1'h0, vmon_en);
        cmp_bit(1'h1, exp_q.size() == 0);
        if (i >= 600) test_done();
        $display("test %0d done", t);
    endtask
    // page write monitor takes the oldest note
    always @(negedge mclk) begin
        if (arr_wr.we === 1'h1 && exp_q.size() == 0) cmp_bit(1'h0, 1'h1);
        else if (arr_wr.we === 1'h1) cmp_wr(exp_q.pop_front(), arr_wr);
    end
    // main sequence
    initial begin
        logic ack;
        sys_rst = 1'h1;
        low_volt = 1'h0;
        void'($urandom(83315));
        strap = 3'($urandom);
        repeat (16) @(posedge mclk);
        #1;
        sys_rst = 1'h0;
        repeat (4) @(posedge mclk);
        wframe(strap, 13'h01F0, 64, 1'h1, 1'h1, ack);
        cmp_bit(1'h1, ack);
        wframe(strap, 13'h0000, 0, 1'h1, 1'h1, ack);
        cmp_bit(1'h0, ack);
        cmp_bit(1'h1, vmon_en);
        wait_idle(1);
        wframe(strap, 13'h0A1A, 66, 1'h1, 1'h1, ack);
        wait_idle(2);
        wframe(strap, 13'h1FFD, 5, 1'h1, 1'h1, ack);
        wait_idle(3);
        wframe(strap ^ 3'h2, 13'h0100, 4, 1'h1, 1'h1, ack);
        cmp_bit(1'h0, ack);
        wait_idle(4);
        wframe(strap, 13'h0200, 2, 1'h0, 1'h1, ack);
        wframe(strap, 13'h0300, 1, 1'h1, 1'h1, ack);
        wait_idle(5);
        @(posedge mclk);
        #1;
        low_volt = 1'h1;
        wframe(strap, 13'h0400, 8, 1'h1, 1'h0, ack);
        wait_idle(6);
        low_volt = 1'h0;
        test_done();
    end
endmodule
bind epc_top epc_checker #(.PAGE_CYCLES(PAGE_CYCLES)) i_chk (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_addr_pin_0_i(chip_addr_pin_0_i), .chip_addr_pin_1_i(chip_addr_pin_1_i),
    .chip_addr_pin_2_i(chip_addr_pin_2_i), .low_volt_i(low_volt_i), .vmon_en_o(vmon_en_o),
    .arr_wr_o(arr_wr_o), .busy_o(busy_o));
